/* File: rtl/npi_regs.svh */
// Register indices, field positions, reset values and timing counts
`ifndef NPI_REGS_SVH
`define NPI_REGS_SVH
`define NPI_IDX_PROG_CTRL 16'h103B
`define NPI_IDX_EPROM_CTRL 16'h1036
`define NPI_IDX_PROTECT 16'h1035
`define NPI_IDX_PUMP_OPT 16'h1039
`define NPI_PC_EPROM_LATCH_ON 5
`define NPI_PC_BYTE 4
`define NPI_PC_ROW 3
`define NPI_PC_ERASE 2
`define NPI_PC_EEPROM_LATCH_ON 1
`define NPI_PC_PROGRAM_VOLTAGE_ON 0
`define NPI_EC_MBE 7
`define NPI_EC_EPROM_LATCH_ON 5
`define NPI_EC_EXTRA_COLUMN_SELECT 4
`define NPI_EC_EXTRA_ROW_SELECT 3
`define NPI_EC_T1 2
`define NPI_EC_T0 1
`define NPI_EC_PGM 0
`define NPI_BP_CONFIG_PROTECT 4
`define NPI_OPT_PUMP_CLOCK_SELECT 6
`define NPI_PROG_CTRL_RST 8'h00
`define NPI_EPROM_CTRL_RST 8'h00
`define NPI_PROTECT_RST 5'h1F
`define NPI_PUMP_OPT_RST 1'b0
`define NPI_PROT_WINDOW_ECYC 7'd64
`define NPI_CONFIG_ADDR 16'h103F
`define NPI_EPROM_FIRST 16'hD000
`define NPI_EE_FIRST 16'hB600
`define NPI_EE_LAST 16'hB7FF
`endif

/* File: rtl/npi_pkg.sv */
// Types shared by the programming interlock
package npi_pkg;
  typedef enum logic [1:0] {NPI_PROGRAM, NPI_BULK, NPI_ROW, NPI_BYTE} npi_erase_t;
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] pc;
    logic [7:0] ec;
    logic [4:0] bp;
    logic pump_clock_select;
    logic [7:0] ediv;
    logic [6:0] ecyc;
    logic win_open;
    logic armed;
    logic [15:0] ep_addr;
    logic [7:0] ep_data;
    logic [15:0] ee_addr;
    logic [7:0] ee_data;
  } npi_state_t;
endpackage

/* File: rtl/npi_top.sv */
// Programming control and interlock for the EPROM and EEPROM arrays
`timescale 1ns/10ps
`default_nettype none
`include "npi_regs.svh"

// Function
// - EPROM latch on: array writes capture address and data, array reads off.
// - EPROM latch bit always readable; its write is ignored while voltage is on.
// - Voltage bit readable; writable only while either latch bit is already set.
// - Voltage bit set connects programming voltage; clear disconnects it.
// - Combined variant never holds both latch bits set together.
// - Dual-byte programming treats address bit 5 as don't care.
// - Dual-byte bit reads 0 in normal modes, writable only in special modes.
// - Separate EPROM latch bit readable; write ignored while its voltage bit set.
// - Extra columns: user array off, address bits 13:5 used, special only.
// - Extra rows: user array off, address bits 7:0 used, special only.
// - Two-bit test field selects stress modes, special only, reads 0 otherwise.
// - Separate EPROM voltage bit writable only while its latch bit is set.
// - Erased EEPROM bit is 1; programming only drives bits to 0.
// - EEPROM latch clear: EEPROM reads like plain ROM.
// - Pump clock select: 0 picks E clock, 1 picks RC oscillator.
// - Voltage needs latch write, then valid EEPROM write, then latch plus voltage.
// - One write setting EEPROM latch and voltage together leaves both clear.
// - Protect bits reset to 1; clearable only in first 64 E cycles normally.
// - Writing 1 to protect bits always works; special modes allow any writes.
// - Config-protect bit set refuses programming or erasing the config byte.
// - Four protect bits guard four fixed EEPROM blocks.
// - Relocatable variant: each bit guards one 512-byte quarter at base nibble.
// - EEPROM latch set: paths set for programming, array unreadable.
// - Erase size: bulk, 16-byte row, or single byte when byte bit set.
module npi_top
  import npi_pkg::*;
#(
  parameter bit SEPARATE_EPROM = 1'b0,
  parameter bit EE_RELOCATABLE = 1'b0,
  parameter int E_DIV = 4
) (
  input wire logic CLK_SYS,
  input wire logic RESETN,
  input wire logic [15:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic SPECIAL_MODE,
  input wire logic [3:0] EE_BASE,
  input wire logic MEM_WRITE,
  input wire logic [15:0] MEM_ADDR,
  input wire logic [7:0] MEM_WDATA,
  output logic EPROM_READ_EN,
  output logic [15:0] EPROM_LAT_ADDR,
  output logic [7:0] EPROM_LAT_DATA,
  output logic EPROM_DUAL_BYTE,
  output logic [13:0] EPROM_ARRAY_ADDR,
  output logic EPROM_USER_EN,
  output logic [1:0] EPROM_TEST_MODE,
  output logic EPROM_VPP_ON,
  output logic EE_READ_EN,
  output logic [15:0] EE_LAT_ADDR,
  output logic [7:0] EE_CLEAR_MASK,
  output logic EE_VPP_ON,
  output logic EE_PROG_GO,
  output logic [1:0] EE_ERASE_SIZE,
  output logic PUMP_CLK_SEL,
  output logic PROTECT_OPEN
);

  initial begin
    if (E_DIV < 1 || E_DIV > 256) begin
      $error("E_DIV out of range");
    end
  end

  localparam logic [15:0] BLK_LO [4] = '{16'hB600, 16'hB620, 16'hB660, 16'hB6E0};
  localparam logic [15:0] BLK_HI [4] = '{16'hB61F, 16'hB65F, 16'hB6DF, 16'hB7FF};

  npi_state_t state_reg;
  npi_state_t state_next;
  logic [3:0] blk_hit;
  logic eprom_latch_on_eff;
  logic is_cfg;
  logic bulk;
  logic target_ok;

  // Protection decode of the latched EEPROM address
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_blk
      if (EE_RELOCATABLE) begin : g_rel
        assign blk_hit[gi] = state_reg.ee_addr[15:12] == EE_BASE && state_reg.ee_addr[11]
          && state_reg.ee_addr[10:9] == 2'(gi);
      end else begin : g_fix
        assign blk_hit[gi] = state_reg.ee_addr >= BLK_LO[gi]
          && state_reg.ee_addr <= BLK_HI[gi];
      end
    end
  endgenerate

  function automatic logic ee_space(input logic [15:0] a, input logic [3:0] base);
    if (EE_RELOCATABLE) begin
      ee_space = a[15:12] == base && a[11];
    end else begin
      ee_space = a >= `NPI_EE_FIRST && a <= `NPI_EE_LAST;
    end
  endfunction

  assign eprom_latch_on_eff = SEPARATE_EPROM ? state_reg.ec[`NPI_EC_EPROM_LATCH_ON] : state_reg.pc[`NPI_PC_EPROM_LATCH_ON];
  assign is_cfg = state_reg.ee_addr == `NPI_CONFIG_ADDR;
  assign bulk = state_reg.pc[`NPI_PC_ERASE] && !state_reg.pc[`NPI_PC_BYTE]
    && !state_reg.pc[`NPI_PC_ROW];
  always_comb begin
    if (is_cfg) begin
      target_ok = !state_reg.bp[`NPI_BP_CONFIG_PROTECT];
    end else if (bulk) begin
      target_ok = state_reg.bp[3:0] == 4'h0;
    end else begin
      target_ok = (blk_hit & state_reg.bp[3:0]) == 4'h0;
    end
  end

  always_comb begin
    logic first;
    logic wr_go;
    logic [7:0] wd;
    logic [7:0] rd;
    logic e_tick;
    logic clr_ok;
    logic n_eprom_latch_on;
    logic n_eeprom_latch_on;
    logic n_program_voltage_on;
    first = 1'b0;
    wr_go = 1'b0;
    wd = AVS_WRITEDATA[7:0];
    rd = 8'h00;
    e_tick = 1'b0;
    clr_ok = 1'b0;
    n_eprom_latch_on = 1'b0;
    n_eeprom_latch_on = 1'b0;
    n_program_voltage_on = 1'b0;
    state_next = state_reg;
    // One wait state per access
    first = (AVS_READ || AVS_WRITE) && !state_reg.ack;
    state_next.ack = first;
    wr_go = AVS_WRITE && state_reg.ack && AVS_BYTEENABLE[0];
    // E clock enable and protect window
    e_tick = state_reg.ediv == 8'(E_DIV - 1);
    state_next.ediv = e_tick ? 8'h00 : state_reg.ediv + 8'h01;
    if (e_tick && state_reg.win_open) begin
      state_next.ecyc = state_reg.ecyc + 7'd1;
      if (state_reg.ecyc + 7'd1 == `NPI_PROT_WINDOW_ECYC) begin
        state_next.win_open = 1'b0;
      end
    end
    clr_ok = state_reg.win_open || SPECIAL_MODE;
    // Read data
    case (AVS_ADDRESS)
      `NPI_IDX_PROG_CTRL: begin
        rd = state_reg.pc;
      end
      `NPI_IDX_EPROM_CTRL: begin
        if (SEPARATE_EPROM) begin
          rd = state_reg.ec & (SPECIAL_MODE ? 8'hBF : 8'h21);
        end
      end
      `NPI_IDX_PROTECT: begin
        rd = {3'b000, state_reg.bp};
      end
      `NPI_IDX_PUMP_OPT: begin
        rd[`NPI_OPT_PUMP_CLOCK_SELECT] = state_reg.pump_clock_select;
      end
      default: begin
        rd = 8'h00;
      end
    endcase
    if (first && AVS_READ) begin
      state_next.rdata = {24'h00_0000, rd};
    end
    // Register writes
    if (wr_go) begin
      case (AVS_ADDRESS)
        `NPI_IDX_PROG_CTRL: begin
          state_next.pc[7:2] = wd[7:2];
          n_eprom_latch_on = state_reg.pc[`NPI_PC_EPROM_LATCH_ON];
          if (!state_reg.pc[`NPI_PC_PROGRAM_VOLTAGE_ON]) begin
            n_eprom_latch_on = wd[`NPI_PC_EPROM_LATCH_ON];
          end
          if (SEPARATE_EPROM) begin
            n_eprom_latch_on = 1'b0;
          end
          n_eeprom_latch_on = wd[`NPI_PC_EEPROM_LATCH_ON];
          n_program_voltage_on = state_reg.pc[`NPI_PC_PROGRAM_VOLTAGE_ON];
          if (state_reg.pc[`NPI_PC_EPROM_LATCH_ON] || state_reg.pc[`NPI_PC_EEPROM_LATCH_ON]) begin
            n_program_voltage_on = wd[`NPI_PC_PROGRAM_VOLTAGE_ON];
          end
          if (wd[`NPI_PC_PROGRAM_VOLTAGE_ON] && !state_reg.pc[`NPI_PC_PROGRAM_VOLTAGE_ON] && !state_reg.pc[`NPI_PC_EPROM_LATCH_ON]
              && !state_reg.armed) begin
            n_program_voltage_on = 1'b0;
          end
          if (wd[`NPI_PC_EEPROM_LATCH_ON] && wd[`NPI_PC_PROGRAM_VOLTAGE_ON] && !state_reg.pc[`NPI_PC_EEPROM_LATCH_ON]) begin
            n_eeprom_latch_on = 1'b0;
            n_program_voltage_on = 1'b0;
          end
          if (n_eprom_latch_on && n_eeprom_latch_on) begin
            n_eprom_latch_on = state_reg.pc[`NPI_PC_EPROM_LATCH_ON];
            n_eeprom_latch_on = state_reg.pc[`NPI_PC_EEPROM_LATCH_ON];
          end
          state_next.pc[`NPI_PC_EPROM_LATCH_ON] = n_eprom_latch_on;
          state_next.pc[`NPI_PC_EEPROM_LATCH_ON] = n_eeprom_latch_on;
          state_next.pc[`NPI_PC_PROGRAM_VOLTAGE_ON] = n_program_voltage_on;
          if (!n_eeprom_latch_on) begin
            state_next.armed = 1'b0;
          end
        end
        `NPI_IDX_EPROM_CTRL: begin
          if (SEPARATE_EPROM) begin
            if (SPECIAL_MODE) begin
              state_next.ec[`NPI_EC_MBE] = wd[`NPI_EC_MBE];
              state_next.ec[`NPI_EC_EXTRA_COLUMN_SELECT] = wd[`NPI_EC_EXTRA_COLUMN_SELECT];
              state_next.ec[`NPI_EC_EXTRA_ROW_SELECT] = wd[`NPI_EC_EXTRA_ROW_SELECT];
              state_next.ec[`NPI_EC_T1:`NPI_EC_T0] = wd[`NPI_EC_T1:`NPI_EC_T0];
            end
            if (!state_reg.ec[`NPI_EC_PGM]) begin
              state_next.ec[`NPI_EC_EPROM_LATCH_ON] = wd[`NPI_EC_EPROM_LATCH_ON];
            end
            if (state_reg.ec[`NPI_EC_EPROM_LATCH_ON]) begin
              state_next.ec[`NPI_EC_PGM] = wd[`NPI_EC_PGM];
            end
          end
        end
        `NPI_IDX_PROTECT: begin
          for (int i = 0; i < 5; i++) begin
            if (wd[i] || clr_ok) begin
              state_next.bp[i] = wd[i];
            end
          end
        end
        `NPI_IDX_PUMP_OPT: begin
          state_next.pump_clock_select = wd[`NPI_OPT_PUMP_CLOCK_SELECT];
        end
        default: begin
          state_next.pump_clock_select = state_reg.pump_clock_select;
        end
      endcase
    end
    // Array writes captured by the latches
    if (MEM_WRITE) begin
      if (eprom_latch_on_eff && MEM_ADDR >= `NPI_EPROM_FIRST) begin
        state_next.ep_addr = MEM_ADDR;
        state_next.ep_data = MEM_WDATA;
      end
      if (state_reg.pc[`NPI_PC_EEPROM_LATCH_ON] && !state_reg.pc[`NPI_PC_PROGRAM_VOLTAGE_ON]
          && (ee_space(MEM_ADDR, EE_BASE) || MEM_ADDR == `NPI_CONFIG_ADDR)) begin
        state_next.ee_addr = MEM_ADDR;
        state_next.ee_data = MEM_WDATA;
        state_next.armed = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESETN) begin
    if (!RESETN) begin
      state_reg <= '0;
      state_reg.pc <= `NPI_PROG_CTRL_RST;
      state_reg.ec <= `NPI_EPROM_CTRL_RST;
      state_reg.bp <= `NPI_PROTECT_RST;
      state_reg.pump_clock_select <= `NPI_PUMP_OPT_RST;
      state_reg.win_open <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  // Bus answer
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !state_reg.ack;
  assign AVS_READDATA = state_reg.rdata;

  // EPROM side
  assign EPROM_READ_EN = !eprom_latch_on_eff;
  assign EPROM_LAT_ADDR = state_reg.ep_addr;
  assign EPROM_LAT_DATA = state_reg.ep_data;
  assign EPROM_DUAL_BYTE = SEPARATE_EPROM && state_reg.ec[`NPI_EC_MBE];
  always_comb begin
    EPROM_ARRAY_ADDR = state_reg.ep_addr[13:0];
    if (EPROM_DUAL_BYTE) begin
      EPROM_ARRAY_ADDR[5] = 1'b0;
    end
    if (SEPARATE_EPROM && state_reg.ec[`NPI_EC_EXTRA_COLUMN_SELECT]) begin
      EPROM_ARRAY_ADDR = {state_reg.ep_addr[13:5], 5'b0_0000};
    end else if (SEPARATE_EPROM && state_reg.ec[`NPI_EC_EXTRA_ROW_SELECT]) begin
      EPROM_ARRAY_ADDR = {6'b00_0000, state_reg.ep_addr[7:0]};
    end
  end
  assign EPROM_USER_EN = !(SEPARATE_EPROM
    && (state_reg.ec[`NPI_EC_EXTRA_COLUMN_SELECT] || state_reg.ec[`NPI_EC_EXTRA_ROW_SELECT]));
  assign EPROM_TEST_MODE = SEPARATE_EPROM ? state_reg.ec[`NPI_EC_T1:`NPI_EC_T0] : 2'b00;
  assign EPROM_VPP_ON = SEPARATE_EPROM ? state_reg.ec[`NPI_EC_PGM]
    : state_reg.pc[`NPI_PC_PROGRAM_VOLTAGE_ON];

  // EEPROM side
  assign EE_READ_EN = !state_reg.pc[`NPI_PC_EEPROM_LATCH_ON];
  assign EE_LAT_ADDR = state_reg.ee_addr;
  assign EE_CLEAR_MASK = ~state_reg.ee_data;
  assign EE_VPP_ON = state_reg.pc[`NPI_PC_PROGRAM_VOLTAGE_ON];
  assign EE_PROG_GO = state_reg.pc[`NPI_PC_PROGRAM_VOLTAGE_ON] && state_reg.pc[`NPI_PC_EEPROM_LATCH_ON]
    && target_ok;
  always_comb begin
    npi_erase_t sz;
    sz = NPI_PROGRAM;
    if (state_reg.pc[`NPI_PC_ERASE]) begin
      if (state_reg.pc[`NPI_PC_BYTE]) begin
        sz = NPI_BYTE;
      end else if (state_reg.pc[`NPI_PC_ROW]) begin
        sz = NPI_ROW;
      end else begin
        sz = NPI_BULK;
      end
    end
    EE_ERASE_SIZE = sz;
  end
  assign PUMP_CLK_SEL = state_reg.pump_clock_select;
  assign PROTECT_OPEN = state_reg.win_open;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESETN);

  logic pc_wr;
  assign pc_wr = AVS_WRITE && state_reg.ack && AVS_BYTEENABLE[0]
    && AVS_ADDRESS == `NPI_IDX_PROG_CTRL;

  eprom_read_off_a: assert property (eprom_latch_on_eff |-> !EPROM_READ_EN)
    else $error("EPROM readable while latched");
  eprom_latch_on_hold_a: assert property (pc_wr && state_reg.pc[`NPI_PC_PROGRAM_VOLTAGE_ON]
    |=> $stable(state_reg.pc[`NPI_PC_EPROM_LATCH_ON])) else $error("Latch changed under voltage");
  voltage_gate_a: assert property (pc_wr && !state_reg.pc[`NPI_PC_EPROM_LATCH_ON]
    && !state_reg.pc[`NPI_PC_EEPROM_LATCH_ON] |=> $stable(state_reg.pc[`NPI_PC_PROGRAM_VOLTAGE_ON]))
    else $error("Voltage bit written without latch");
  vpp_follow_a: assert property (EE_VPP_ON == state_reg.pc[`NPI_PC_PROGRAM_VOLTAGE_ON])
    else $error("Voltage output disagrees with bit");
  latch_excl_a: assert property (!(state_reg.pc[`NPI_PC_EPROM_LATCH_ON]
    && state_reg.pc[`NPI_PC_EEPROM_LATCH_ON])) else $error("Both latch bits set");
  ee_rom_read_a: assert property (!state_reg.pc[`NPI_PC_EEPROM_LATCH_ON] |-> EE_READ_EN)
    else $error("EEPROM not readable with latch clear");
  both_set_a: assert property (pc_wr && AVS_WRITEDATA[1:0] == 2'b11
    && !state_reg.pc[`NPI_PC_EEPROM_LATCH_ON] |=> state_reg.pc[1:0] == 2'b00)
    else $error("Latch and voltage set in one write");
  prot_closed_a: assert property (AVS_WRITE && state_reg.ack && AVS_BYTEENABLE[0]
    && AVS_ADDRESS == `NPI_IDX_PROTECT && !state_reg.win_open && !SPECIAL_MODE
    |=> ($past(state_reg.bp) & ~state_reg.bp) == 5'h00)
    else $error("Protect bit cleared after window");
  prot_window_a: assert property ($fell(state_reg.win_open)
    |-> $past(state_reg.ecyc) == 7'd63) else $error("Window closed at wrong count");
  mbe_normal_a: assert property (!SPECIAL_MODE && AVS_READ && !state_reg.ack
    && AVS_ADDRESS == `NPI_IDX_EPROM_CTRL |=> !AVS_READDATA[7])
    else $error("Dual-byte bit visible in normal mode");
  cfg_guard_a: assert property (is_cfg && state_reg.bp[`NPI_BP_CONFIG_PROTECT]
    |-> !EE_PROG_GO) else $error("Config byte open while protected");
  ee_capture_a: assert property (MEM_WRITE && state_reg.pc[`NPI_PC_EEPROM_LATCH_ON]
    && !state_reg.pc[`NPI_PC_PROGRAM_VOLTAGE_ON] && MEM_ADDR == `NPI_CONFIG_ADDR
    |=> EE_LAT_ADDR == `NPI_CONFIG_ADDR) else $error("Config write not latched");
  ep_capture_a: assert property (MEM_WRITE && eprom_latch_on_eff
    && MEM_ADDR >= `NPI_EPROM_FIRST |=> EPROM_LAT_ADDR == $past(MEM_ADDR))
    else $error("EPROM write not latched");
  pump_write_a: assert property (AVS_WRITE && state_reg.ack && AVS_BYTEENABLE[0]
    && AVS_ADDRESS == `NPI_IDX_PUMP_OPT |=> PUMP_CLK_SEL == $past(AVS_WRITEDATA[6]))
    else $error("Pump clock select not written");
  byte_erase_a: assert property (state_reg.pc[`NPI_PC_ERASE]
    && state_reg.pc[`NPI_PC_BYTE] |-> EE_ERASE_SIZE == 2'h3)
    else $error("Byte bit did not select byte erase");

endmodule
`default_nettype wire

/* File: sim/npi_cpu_model.sv */
// CPU-side model: register bus master and array byte writer
`timescale 1ns/10ps
`default_nettype none
module npi_cpu_model (
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [31:0] readdata,
  output logic [15:0] address,
  output logic read,
  output logic write,
  output logic [31:0] writedata,
  output logic [3:0] byteenable,
  output logic mem_write,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata
);
  initial begin
    address = 16'h0000;
    read = 1'h0;
    write = 1'h0;
    writedata = 32'h0000_0000;
    byteenable = 4'h0;
    mem_write = 1'h0;
    mem_addr = 16'h0000;
    mem_wdata = 8'h00;
  end

  // Request held until waitrequest is sampled low; released lines are scrambled
  task automatic access(input logic wr, input logic [15:0] a, input logic [7:0] d,
      input logic [3:0] be, output logic [7:0] q);
    @(posedge clk);
    address <= a;
    writedata <= {24'h00_0000, d};
    byteenable <= be;
    write <= wr;
    read <= ~wr;
    do @(posedge clk); while (waitrequest !== 1'h0);
    q = readdata[7:0];
    write <= 1'h0;
    read <= 1'h0;
    address <= ~a;
    writedata <= ~{24'h00_0000, d};
  endtask

  // One array byte, stored between the latch write and the voltage write
  task automatic store(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    mem_write <= 1'h1;
    mem_addr <= a;
    mem_wdata <= d;
    @(posedge clk);
    mem_write <= 1'h0;
    mem_addr <= ~a;
    mem_wdata <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: sim/test_npi_top.sv */
// Self-checking bench for the programming interlock
`timescale 1ns/10ps
`default_nettype none
`include "npi_regs.svh"
module test_npi_top;
  typedef struct {logic [15:0] a; logic [7:0] d; logic [3:0] be; logic [7:0] q;} npi_row_t;
  logic clk_sys, rst_n, special;
  logic [15:0] av_addr, mem_addr, eprom_lat_addr, ee_lat_addr;
  logic av_read, av_write, av_wait, mem_write, eprom_read_en, eprom_vpp_on;
  logic ee_read_en, ee_vpp_on, ee_prog_go, pump_sel, protect_open;
  logic [31:0] av_wdata, av_rdata;
  logic [3:0] av_be;
  logic [7:0] mem_wdata, eprom_lat_data, ee_clear_mask;
  logic [1:0] ee_erase_size;
  int n_fail = 0;
  int cmp_count = 0;
  npi_row_t rows [9] = '{
    '{`NPI_IDX_PROTECT, 8'h1D, 4'hF, 8'h1D},
    '{`NPI_IDX_PROG_CTRL, 8'h03, 4'hF, 8'h00},
    '{`NPI_IDX_PROG_CTRL, 8'h01, 4'hF, 8'h00},
    '{`NPI_IDX_PROG_CTRL, 8'h22, 4'hF, 8'h00},
    '{`NPI_IDX_PUMP_OPT, 8'h40, 4'hF, 8'h40},
    '{`NPI_IDX_PUMP_OPT, 8'h00, 4'h0, 8'h40},
    '{`NPI_IDX_PUMP_OPT, 8'h00, 4'hF, 8'h00},
    '{16'h1000, 8'hFF, 4'hF, 8'h00},
    '{`NPI_IDX_EPROM_CTRL, 8'hFF, 4'hF, 8'h00}};
  logic [7:0] ecode [4] = '{8'h06, 8'h0E, 8'h16, 8'h1E};
  logic [1:0] esize [4] = '{2'h1, 2'h2, 2'h3, 2'h3};
  logic [15:0] eaddr [2] = '{16'hB620, 16'hB600};
  logic [15:0] ego [2] = '{16'h0001, 16'h0000};

  npi_top #(.E_DIV(1)) u_dut (.CLK_SYS(clk_sys), .RESETN(rst_n), .AVS_ADDRESS(av_addr),
    .AVS_READ(av_read), .AVS_WRITE(av_write), .AVS_WRITEDATA(av_wdata),
    .AVS_BYTEENABLE(av_be), .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait),
    .SPECIAL_MODE(special), .EE_BASE(4'h0), .MEM_WRITE(mem_write), .MEM_ADDR(mem_addr),
    .MEM_WDATA(mem_wdata), .EPROM_READ_EN(eprom_read_en), .EPROM_LAT_ADDR(eprom_lat_addr),
    .EPROM_LAT_DATA(eprom_lat_data), .EPROM_DUAL_BYTE(), .EPROM_ARRAY_ADDR(),
    .EPROM_USER_EN(), .EPROM_TEST_MODE(), .EPROM_VPP_ON(eprom_vpp_on),
    .EE_READ_EN(ee_read_en), .EE_LAT_ADDR(ee_lat_addr), .EE_CLEAR_MASK(ee_clear_mask),
    .EE_VPP_ON(ee_vpp_on), .EE_PROG_GO(ee_prog_go), .EE_ERASE_SIZE(ee_erase_size),
    .PUMP_CLK_SEL(pump_sel), .PROTECT_OPEN(protect_open));

  npi_cpu_model u_cpu (.clk(clk_sys), .waitrequest(av_wait), .readdata(av_rdata),
    .address(av_addr), .read(av_read), .write(av_write), .writedata(av_wdata),
    .byteenable(av_be), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata));

  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end

  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [3:0] be);
    logic [7:0] q;
    u_cpu.access(1'h1, a, d, be, q);
  endtask

  task automatic chk_rd(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    u_cpu.access(1'h0, a, 8'h00, 4'hF, q);
    chk("readback", {8'h00, exp}, {8'h00, q});
  endtask

  initial begin
    repeat (3000) @(posedge clk_sys);
    n_fail++;
    print_verdict();
  end

  initial begin
    rst_n = 1'h0;
    special = 1'h0;
    repeat (8) @(posedge clk_sys);
    rst_n <= 1'h1;
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d, rows[i].be);
      chk_rd(rows[i].a, rows[i].q);
    end
    wr(`NPI_IDX_PUMP_OPT, 8'h40, 4'hF);
    @(negedge clk_sys);
    chk("pump_clk_sel", 16'h0001, {15'h0000, pump_sel});
    for (int k = 0; k < 300 && protect_open !== 1'h0; k++) @(posedge clk_sys);
    chk("protect_open", 16'h0000, {15'h0000, protect_open});
    wr(`NPI_IDX_PROTECT, 8'h00, 4'hF);
    chk_rd(`NPI_IDX_PROTECT, 8'h1D);
    wr(`NPI_IDX_PROTECT, 8'h1F, 4'hF);
    chk_rd(`NPI_IDX_PROTECT, 8'h1F);
    special <= 1'h1;
    wr(`NPI_IDX_PROTECT, 8'h1D, 4'hF);
    chk_rd(`NPI_IDX_PROTECT, 8'h1D);
    special <= 1'h0;
    wr(`NPI_IDX_PROG_CTRL, 8'h20, 4'hF);
    u_cpu.store(16'hD010, 8'h3C);
    @(negedge clk_sys);
    chk("eprom_read_en", 16'h0000, {15'h0000, eprom_read_en});
    chk("eprom_lat_addr", 16'hD010, eprom_lat_addr);
    chk("eprom_lat_data", 16'h003C, {8'h00, eprom_lat_data});
    wr(`NPI_IDX_PROG_CTRL, 8'h21, 4'hF);
    @(negedge clk_sys);
    chk("eprom_vpp_on", 16'h0001, {15'h0000, eprom_vpp_on});
    wr(`NPI_IDX_PROG_CTRL, 8'h00, 4'hF);
    chk_rd(`NPI_IDX_PROG_CTRL, 8'h20);
    wr(`NPI_IDX_PROG_CTRL, 8'h00, 4'hF);
    chk_rd(`NPI_IDX_PROG_CTRL, 8'h00);
    for (int i = 0; i < 2; i++) begin
      wr(`NPI_IDX_PROG_CTRL, 8'h02, 4'hF);
      wr(`NPI_IDX_PROG_CTRL, 8'h03, 4'hF);
      chk_rd(`NPI_IDX_PROG_CTRL, 8'h02);
      @(negedge clk_sys);
      chk("ee_read_en", 16'h0000, {15'h0000, ee_read_en});
      u_cpu.store(eaddr[i], 8'hA5);
      @(negedge clk_sys);
      chk("ee_lat_addr", eaddr[i], ee_lat_addr);
      chk("ee_clear_mask", 16'h005A, {8'h00, ee_clear_mask});
      wr(`NPI_IDX_PROG_CTRL, 8'h03, 4'hF);
      @(negedge clk_sys);
      chk("ee_vpp_on", 16'h0001, {15'h0000, ee_vpp_on});
      chk("ee_prog_go", ego[i], {15'h0000, ee_prog_go});
      wr(`NPI_IDX_PROG_CTRL, 8'h02, 4'hF);
      wr(`NPI_IDX_PROG_CTRL, 8'h00, 4'hF);
    end
    @(negedge clk_sys);
    chk("ee_read_en", 16'h0001, {15'h0000, ee_read_en});
    for (int i = 0; i < 4; i++) begin
      wr(`NPI_IDX_PROG_CTRL, ecode[i], 4'hF);
      @(negedge clk_sys);
      chk("erase_size", {14'h0000, esize[i]}, {14'h0000, ee_erase_size});
    end
    @(posedge clk_sys);
    rst_n <= 1'h0;
    @(negedge clk_sys);
    chk("reset_ee_read_en", 16'h0001, {15'h0000, ee_read_en});
    chk("reset_protect_open", 16'h0001, {15'h0000, protect_open});
    @(posedge clk_sys);
    rst_n <= 1'h1;
    chk_rd(`NPI_IDX_PROTECT, 8'h1F);
    chk_rd(`NPI_IDX_PROG_CTRL, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire
